/* rfsw_defines.vh */
// constants for the rf control pin block: offsets, fields, resets
// assumes inclusion by bare name from the rfsw design files
`ifndef RFSW_DEFINES_VH
`define RFSW_DEFINES_VH
// ****************************************
// register offsets
// ****************************************
`define RFSW_ADDR_ANTENNA_ONE_ENERGY    8'h73
`define RFSW_ADDR_ANTENNA_TWO_ENERGY    8'h74
`define RFSW_ADDR_OVR        8'h75
// ****************************************
// override register fields
// ****************************************
`define RFSW_OVR_TRX_EN      0
`define RFSW_OVR_ANT_EN      1
`define RFSW_OVR_AUX_EN      2
`define RFSW_OVR_TRX_LVL     4
`define RFSW_OVR_ANT_LVL     5
`define RFSW_OVR_AUX_LVL     6
// ****************************************
// reset values
// ****************************************
`define RFSW_RST_OVR         8'h00
`define RFSW_RST_ED          8'h00
`endif

/* rfsw_energy_reg.v */
// one per-antenna energy result register, read only to software
// assumes the diversity engine supplies capture strobes and clear events
`timescale 1ns/1ps
`include "rfsw_defines.vh"
module rfsw_energy_reg #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         srst,
    input  wire         capture,
    input  wire [W-1:0] value,
    input  wire         clear,
    output wire [W-1:0] q
);
    reg [W-1:0] val_ff;
    // capture wins over clear so a fresh result is kept
    always @(posedge clk) begin
        if (srst) begin
            val_ff <= `RFSW_RST_ED;
        end else if (capture) begin
            val_ff <= value;
        end else if (clear) begin
            val_ff <= `RFSW_RST_ED;
        end
    end
    assign q = val_ff;
endmodule // rfsw_energy_reg

/* rfsw_pin_mux.v */
// forced-setting resolver for the three rf control pins
// assumes all inputs are synchronous levels; output is combinational
`timescale 1ns/1ps
`include "rfsw_defines.vh"
module rfsw_pin_mux (
    input  wire       forced_ok,
    input  wire       dpdt,
    input  wire [7:0] ovr,
    input  wire       trx_pol,
    input  wire       fix_en,
    input  wire       fix_ant,
    input  wire       tx_or_cca,
    input  wire       ant_two,
    input  wire       norm_ant,
    input  wire       norm_trx,
    input  wire       norm_aux,
    output reg        ant_pin,
    output reg        trx_pin,
    output reg        aux_pin
);
    reg fix_act;
    // priority: override register, polarity, fixed antenna, search result
    always @* begin
        fix_act = fix_en & tx_or_cca;
        ant_pin = norm_ant;
        trx_pin = norm_trx;
        aux_pin = norm_aux;
        if (forced_ok) begin
            trx_pin = trx_pol;
            ant_pin = fix_act ? fix_ant : ant_two;
        end
        if (!dpdt) begin
            if (ovr[`RFSW_OVR_TRX_EN]) trx_pin = ovr[`RFSW_OVR_TRX_LVL];
            if (ovr[`RFSW_OVR_ANT_EN]) ant_pin = ovr[`RFSW_OVR_ANT_LVL];
            if (ovr[`RFSW_OVR_AUX_EN]) aux_pin = ovr[`RFSW_OVR_AUX_LVL];
        end
    end
endmodule // rfsw_pin_mux

/* rfsw_top.v */
// rf control pin block: override register, energy results, pin drive
// assumes a byte register port decoded by the host interface
//
// How it works
// - forced antenna pin follows antenna-two bit, or fixed choice during tx/cca.
// - antenna-one selected bit never changes the forced antenna pin level.
// - forced tx/rx pin level equals the switch polarity bit.
// - override register has no effect while double throw switch selected.
// - priority: override, polarity, fixed tx antenna, antenna-two bit.
// - writing zero to selected bits in reception changes searched antenna; not modelled here, selected bits are input levels only.
// - read-only register gives antenna one energy, valid with diversity on.
// - read-only register gives antenna two energy, valid with diversity on.
// - both energy registers clear on completion irq clear or auto restart.
// - per-pin enable bits 2,1,0 hand the pin to the override.
// - override level bits 6,5,4 give driven levels for those pins.
// - fixed antenna only for host tx-on or host cca, not auto ack.
// - spdt default polarity: low antenna one, high antenna two.
`timescale 1ns/1ps
`include "rfsw_defines.vh"
module rfsw_top #(
    parameter ED_W = 8
) (
    input  wire            CLK_SYS,
    input  wire            SRST,
    input  wire            REG_WR,
    input  wire            REG_RD,
    input  wire [7:0]      REG_ADDR,
    input  wire [7:0]      REG_WDATA,
    output reg  [7:0]      REG_RDATA,
    input  wire            DIV_ENABLE,
    input  wire            DOUBLE_THROW_SEL,
    input  wire            DIV_IRQ_MASK_BIT,
    input  wire            TXRX_POLARITY,
    input  wire            FIXED_TX_ANT_EN,
    input  wire            FIXED_TX_ANT_CHOICE,
    input  wire            HOST_TX_OR_CCA,
    input  wire            ANT_TWO_SELECTED,
    input  wire            ANT_ONE_SELECTED,
    input  wire            NORMAL_ANT,
    input  wire            NORMAL_TRX,
    input  wire            NORMAL_AUX,
    input  wire            ED1_CAPTURE,
    input  wire            ED2_CAPTURE,
    input  wire [ED_W-1:0] ED_VALUE,
    input  wire            DIV_DONE_IRQ_CLEAR,
    input  wire            DIV_AUTO_RESTART,
    output reg             ANTENNA_SELECT_PIN,
    output reg             TX_RX_SWITCH_PIN,
    output reg             AUXILIARY_CONTROL_PIN
);
    // ****************************************
    // register storage
    // ****************************************
    reg  [7:0]      ovr_ff;
    wire [7:0]      nxt_ovr;
    wire [ED_W-1:0] ed1_q;
    wire [ED_W-1:0] ed2_q;
    wire [2*ED_W-1:0] ed_q_all;
    wire [1:0]      ed_capture;
    wire            ed_clear;
    wire            forced_ok;
    wire            mux_ant;
    wire            mux_trx;
    wire            mux_aux;
    reg  [7:0]      nxt_rdata;

    // whole byte stored, reserved bits included
    assign nxt_ovr = (REG_WR && REG_ADDR == `RFSW_ADDR_OVR) ? REG_WDATA : ovr_ff;

    // override register
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            ovr_ff <= `RFSW_RST_OVR;
        end else begin
            ovr_ff <= nxt_ovr;
        end
    end

    // ****************************************
    // energy results
    // ****************************************
    assign ed_clear = DIV_DONE_IRQ_CLEAR | DIV_AUTO_RESTART;

    // captures only count while diversity runs
    assign ed_capture = {ED2_CAPTURE, ED1_CAPTURE} & {2{DIV_ENABLE}};

    // one result register per antenna
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ed
            rfsw_energy_reg #(.W(ED_W)) u_ed (
                .clk     (CLK_SYS),
                .srst    (SRST),
                .capture (ed_capture[gi]),
                .value   (ED_VALUE),
                .clear   (ed_clear),
                .q       (ed_q_all[gi*ED_W +: ED_W])
            );
        end
    endgenerate

    // split per antenna for the read path
    assign ed1_q = ed_q_all[ED_W-1:0];
    assign ed2_q = ed_q_all[2*ED_W-1:ED_W];

    // ****************************************
    // read path
    // ****************************************
    // unmapped offsets read zero
    always @* begin
        nxt_rdata = 8'h00;
        case (REG_ADDR)
            `RFSW_ADDR_ANTENNA_ONE_ENERGY: nxt_rdata = ed1_q[7:0];
            `RFSW_ADDR_ANTENNA_TWO_ENERGY: nxt_rdata = ed2_q[7:0];
            `RFSW_ADDR_OVR:     nxt_rdata = ovr_ff;
            default:            nxt_rdata = 8'h00;
        endcase
    end

    // read data registered on read strobe
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= nxt_rdata;
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    // antenna-one bit deliberately not wired into the resolver
    assign forced_ok = ~DIV_ENABLE & ~DOUBLE_THROW_SEL & ~DIV_IRQ_MASK_BIT;

    rfsw_pin_mux u_mux (
        .forced_ok (forced_ok),
        .dpdt      (DOUBLE_THROW_SEL),
        .ovr       (nxt_ovr),
        .trx_pol   (TXRX_POLARITY),
        .fix_en    (FIXED_TX_ANT_EN),
        .fix_ant   (FIXED_TX_ANT_CHOICE),
        .tx_or_cca (HOST_TX_OR_CCA),
        .ant_two   (ANT_TWO_SELECTED),
        .norm_ant  (NORMAL_ANT),
        .norm_trx  (NORMAL_TRX),
        .norm_aux  (NORMAL_AUX),
        .ant_pin   (mux_ant),
        .trx_pin   (mux_trx),
        .aux_pin   (mux_aux)
    );

    // pins registered, follow a write at the same edge it lands
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            ANTENNA_SELECT_PIN    <= 1'b0;
            TX_RX_SWITCH_PIN      <= 1'b0;
            AUXILIARY_CONTROL_PIN <= 1'b0;
        end else begin
            ANTENNA_SELECT_PIN    <= mux_ant;
            TX_RX_SWITCH_PIN      <= mux_trx;
            AUXILIARY_CONTROL_PIN <= mux_aux;
        end
    end
endmodule // rfsw_top

/* rfsw_switch_model.sv */
// external spdt antenna switch driven by the antenna control pin
// assumes cmos push-pull control lines from the block
`timescale 1ns/1ps
module rfsw_switch_model (
    input  wire logic       ant_ctl,
    output logic      [1:0] ant_num
);
    // low picks antenna one, high antenna two; cmos drive assumed
    assign ant_num = ant_ctl ? 2'h2 : 2'h1;
endmodule // rfsw_switch_model

/* rfsw_checker.sv */
// assertions on the rf control pin block at its top ports
// assumes one clock domain; bound into every rfsw_top
`timescale 1ns/1ps
module rfsw_checker (
    input wire       CLK_SYS, SRST, REG_WR, REG_RD,
    input wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
    input wire       DIV_ENABLE, DOUBLE_THROW_SEL, DIV_IRQ_MASK_BIT, TXRX_POLARITY,
    input wire       FIXED_TX_ANT_EN, FIXED_TX_ANT_CHOICE, HOST_TX_OR_CCA, ANT_TWO_SELECTED,
    input wire       NORMAL_ANT, NORMAL_TRX, NORMAL_AUX,
    input wire       ANTENNA_SELECT_PIN, TX_RX_SWITCH_PIN, AUXILIARY_CONTROL_PIN
);
    logic [7:0] ovr_ff, nxt_ovr;
    logic [2:0] pins, norm;
    logic       fok, fix;
    // shadow of the override register and forced-mode terms
    assign nxt_ovr = (REG_WR && REG_ADDR == 8'h75) ? REG_WDATA : ovr_ff;
    assign fok = !DIV_ENABLE && !DOUBLE_THROW_SEL && !DIV_IRQ_MASK_BIT;
    assign fix = fok && !nxt_ovr[1] && FIXED_TX_ANT_EN && HOST_TX_OR_CCA;
    assign pins = {AUXILIARY_CONTROL_PIN, ANTENNA_SELECT_PIN, TX_RX_SWITCH_PIN};
    assign norm = {NORMAL_AUX, NORMAL_ANT, NORMAL_TRX};
    always @(posedge CLK_SYS) ovr_ff <= SRST ? 8'h00 : nxt_ovr;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    AST_TRX:
    assert property (fok && !nxt_ovr[0] |=> TX_RX_SWITCH_PIN == $past(TXRX_POLARITY))
        else $error("trx pin level wrong");
    AST_ANT_TWO:
    assert property (fok && !nxt_ovr[1] && !fix |=> ANTENNA_SELECT_PIN == $past(ANT_TWO_SELECTED))
        else $error("antenna pin level wrong");
    AST_ANT_FIX:
    assert property (fix |=> ANTENNA_SELECT_PIN == $past(FIXED_TX_ANT_CHOICE))
        else $error("fixed antenna wrong");
    AST_OVR:
    assert property (!DOUBLE_THROW_SEL |=> ((pins ^ $past(nxt_ovr[6:4])) & $past(nxt_ovr[2:0])) == 3'h0)
        else $error("override level wrong");
    AST_DPDT:
    assert property (DOUBLE_THROW_SEL |=> pins == $past(norm)) else $error("override not blocked");
    AST_NORMAL:
    assert property (!fok && nxt_ovr[2:0] == 3'h0 |=> pins == $past(norm)) else $error("forced leak");
    AST_RD_OVR:
    assert property (REG_RD && !REG_WR && REG_ADDR == 8'h75 |=> REG_RDATA == $past(ovr_ff))
        else $error("override readback wrong");
    AST_RST:
    assert property (disable iff (1'h0) SRST |=> pins == 3'h0) else $error("pins not cleared");
    cover property (fix);
    cover property (DOUBLE_THROW_SEL && nxt_ovr[1]);
    cover property (REG_RD && REG_ADDR == 8'h74);
endmodule // rfsw_checker
bind rfsw_top rfsw_checker u_chk (.*);

/* rfsw_top_tb.sv */
// self-checking bench for rfsw_top with the antenna switch model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module rfsw_top_tb;
    logic        CLK_SYS = '0, SRST = '1, REG_WR = '0, REG_RD = '0, ED1_CAPTURE = '0;
    logic        ED2_CAPTURE = '0, DIV_DONE_IRQ_CLEAR = '0, DIV_AUTO_RESTART = '0;
    logic        DIV_ENABLE, DOUBLE_THROW_SEL, DIV_IRQ_MASK_BIT, TXRX_POLARITY, FIXED_TX_ANT_EN;
    logic        FIXED_TX_ANT_CHOICE, HOST_TX_OR_CCA, ANT_TWO_SELECTED, ANT_ONE_SELECTED;
    logic        NORMAL_TRX, NORMAL_ANT, NORMAL_AUX;
    logic        ANTENNA_SELECT_PIN, TX_RX_SWITCH_PIN, AUXILIARY_CONTROL_PIN;
    logic [7:0]  REG_ADDR = '0, REG_WDATA = '0, ED_VALUE = '0, REG_RDATA, ovr, v1, v2;
    logic [11:0] c = '0;
    logic [2:0]  e, pins;
    logic [1:0]  ant_num;
    int          num_errors = 0, checked = 0, cyc = 0;
    // control levels unpacked from one random word
    assign {NORMAL_AUX, NORMAL_ANT, NORMAL_TRX, ANT_ONE_SELECTED, ANT_TWO_SELECTED, HOST_TX_OR_CCA,
        FIXED_TX_ANT_CHOICE, FIXED_TX_ANT_EN, TXRX_POLARITY, DIV_IRQ_MASK_BIT, DOUBLE_THROW_SEL,
        DIV_ENABLE} = c;
    assign pins = {AUXILIARY_CONTROL_PIN, ANTENNA_SELECT_PIN, TX_RX_SWITCH_PIN};
    rfsw_top dut (.*);
    rfsw_switch_model u_sw (.ant_ctl(ANTENNA_SELECT_PIN), .ant_num(ant_num));
    always #2.5 CLK_SYS = !CLK_SYS;
    // expected pins {aux, ant, trx} from levels and override value
    function automatic logic [2:0] exp_pins(logic [11:0] s, logic [7:0] o);
        logic [2:0] p;
        p = s[11:9];
        if (s[2:0] == 3'h0) begin
            p[0] = s[3];
            p[1] = (s[4] && s[6]) ? s[5] : s[7];
        end
        if (!s[1]) p = (p & ~o[2:0]) | (o[6:4] & o[2:0]);
        return p;
    endfunction
    task automatic chk(string n, logic [7:0] x, logic [7:0] g);
        checked++;
        if (x !== g) begin
            $display("Error %s expected %h seen %h", n, x, g);
            num_errors++;
        end
    endtask
    // one write or read cycle; read data compared a cycle later
    task automatic acc(logic w, logic [7:0] a, logic [7:0] x);
        @(negedge CLK_SYS);
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, x};
        @(negedge CLK_SYS);
        {REG_WR, REG_RD} = 2'h0;
        if (!w) chk("rdata", x, REG_RDATA);
    endtask
    task automatic complete_run();
        if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(83262));
        repeat (6) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        SRST = 1'h0;
        chk("pins", 8'h00, {5'h00, pins});
        for (int a = 8'h73; a < 8'h77; a++) acc(1'h0, a[7:0], 8'h00);
        ovr = 8'h00;
        // let the read strobe fall before the write strobe is driven
        @(negedge CLK_SYS);
        repeat (600) begin
            c = 12'($urandom);
            if ($urandom_range(1)) c[2:0] = 3'h0;
            REG_WR = ($urandom_range(3) == 0);
            REG_ADDR = 8'h75;
            REG_WDATA = 8'($urandom);
            if (REG_WR) ovr = REG_WDATA;
            e = exp_pins(c, ovr);
            @(negedge CLK_SYS);
            chk("pins", {5'h00, e}, {5'h00, pins});
            chk("antenna", {6'h00, e[1] ? 2'h2 : 2'h1}, {6'h00, ant_num});
        end
        REG_WR = 1'h0;
        acc(1'h0, 8'h75, ovr);
        // mid-run reset clears pins and the override register
        SRST = 1'h1;
        repeat (2) @(negedge CLK_SYS);
        SRST = 1'h0;
        chk("pins", 8'h00, {5'h00, pins});
        acc(1'h0, 8'h75, 8'h00);
        c = 12'h001;
        for (int k = 0; k < 2; k++) begin
            v1 = 8'($urandom);
            v2 = 8'($urandom);
            @(negedge CLK_SYS);
            {ED1_CAPTURE, ED_VALUE} = {1'h1, v1};
            @(negedge CLK_SYS);
            {ED1_CAPTURE, ED2_CAPTURE, ED_VALUE} = {2'h1, v2};
            @(negedge CLK_SYS);
            ED2_CAPTURE = 1'h0;
            acc(1'h0, 8'h73, v1);
            acc(1'h0, 8'h74, v2);
            {DIV_DONE_IRQ_CLEAR, DIV_AUTO_RESTART} = k ? 2'h1 : 2'h2;
            @(negedge CLK_SYS);
            {DIV_DONE_IRQ_CLEAR, DIV_AUTO_RESTART} = 2'h0;
            acc(1'h0, 8'h73, 8'h00);
            acc(1'h0, 8'h74, 8'h00);
        end
        // diversity-off capture on antenna one is ignored, register stays zero; capture beats auto restart clear on antenna two
        c = 12'h000;
        {ED1_CAPTURE, ED_VALUE} = {1'h1, v1 | 8'h01};
        @(negedge CLK_SYS);
        {c, ED1_CAPTURE, ED2_CAPTURE, DIV_AUTO_RESTART, ED_VALUE} = {12'h001, 3'h3, v2};
        @(negedge CLK_SYS);
        {ED2_CAPTURE, DIV_AUTO_RESTART} = 2'h0;
        acc(1'h0, 8'h73, 8'h00);
        acc(1'h0, 8'h74, v2);
        complete_run();
    end
endmodule // rfsw_top_tb
